/* File: hw/stp_pkg.sv */
package stp_pkg;

  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS  = 8;
  localparam int ADDR_BITS  = 15;
  localparam int RW_POS     = 15;
  localparam int SYNC_PINS  = 3;

  // Count values at which the last bit of a field is captured.
  localparam logic [3:0] LAST_INSTR_CNT = 4'hF;
  localparam logic [3:0] LAST_DATA_CNT  = 4'h7;
  localparam logic [3:0] CNT_RST        = 4'h0;

  // Positions of the pins inside the synchroniser vector.
  localparam int PIN_SCLK = 2;
  localparam int PIN_SEL  = 1;
  localparam int PIN_DIN  = 0;

  // Idle levels of the pins: clock low, select high, data low.
  localparam logic [2:0] SYNC_RST = 3'h2;

  // Values after reset: three-wire bus, high bit first.
  localparam logic FOUR_WIRE_RST      = 1'b0;
  localparam logic HIGH_BIT_FIRST_RST = 1'b1;

  localparam int FIFO_DEPTH = 2;

  typedef logic [ADDR_BITS-1:0] stp_addr_t;

  typedef struct packed {
    stp_addr_t  addr;
    logic [7:0] data;
  } stp_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10
  } stp_state_t;

endpackage

/* File: hw/stp_pair_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module stp_pair_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    mem <= next_mem;
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule

`default_nettype wire

/* File: hw/stp_target_port.sv */
// How it works
// - With select high, clock and data are ignored and the port returns to idle.
// - Select rising during the instruction or first byte abandons the frame without effect.
// - Completed bytes before an abort take effect; partial or later transfers are dropped.
// - Four-wire mode takes data on data_in_out and returns it on data_out_line.
// - Three-wire mode returns read data on data_in_out and keeps data_out_line off.
// - After any reset the port is in three-wire mode.
// - Outgoing data changes on clock falls; incoming data is captured on clock rises.
// - Data outputs float while select is high or no read data is returned.
// - The instruction is exactly 16 bits; the port only answers, never drives clock.
// - The port never starts frames; it only responds to frames from the host.
// - Instruction bit 15 set means read, cleared means write.
// - Instruction bits 14 to 0 give the byte address of the data phase.
// - Undefined addresses complete normally: writes are passed on to wr_word, reads give zero.
// - Without streaming, every instruction is followed by exactly one data byte.
// - The instruction always comes before the data byte in either bit order.
// - Low bit first: address low to high, then read flag, then data low first.
// - High bit first: read flag, address high to low, then data high first.
// - A single-instruction frame carries one instruction and one data byte.
// - Buffered frames repeat instruction and byte pairs, each decoded on its own.
`timescale 1ns/1ps
`default_nettype none

module stp_target_port #(
  parameter int FIFO_DEPTH = stp_pkg::FIFO_DEPTH
) (
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic            serial_clock_in,
  input  wire logic            bus_select_n,
  input  wire logic            data_in_out_in,
  output logic                 data_in_out_out,
  output logic                 data_in_out_oe,
  output logic                 data_out_line_out,
  output logic                 data_out_line_oe,
  input  wire logic            cfg_wr,
  input  wire logic            cfg_four_wire,
  input  wire logic            cfg_high_bit_first,
  output logic                 four_wire_mode,
  output logic                 high_bit_first_sel,
  output logic                 rd_req,
  output stp_pkg::stp_addr_t   rd_addr,
  input  wire logic [7:0]      rd_data,
  input  wire logic            rd_addr_hit,
  output logic                 wr_valid,
  input  wire logic            wr_ready,
  output stp_pkg::stp_wr_t     wr_word,
  output logic                 write_overrun,
  output logic                 frame_active
);
  import stp_pkg::*;

  logic [SYNC_PINS-1:0] sync_a;
  logic [SYNC_PINS-1:0] sync_b;
  logic [SYNC_PINS-1:0] sync_c;
  logic [SYNC_PINS-1:0] pins;

  assign pins = {serial_clock_in, bus_select_n, data_in_out_in};

  // Every pin passes two flops; the third stage only serves edge detection.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          sync_a[gi] <= SYNC_RST[gi];
          sync_b[gi] <= SYNC_RST[gi];
          sync_c[gi] <= SYNC_RST[gi];
        end else begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  logic sel_n;
  logic din;
  logic sclk_rise;
  logic sclk_fall;

  assign sel_n     = sync_b[PIN_SEL];
  assign din       = sync_b[PIN_DIN];
  assign sclk_rise = sync_b[PIN_SCLK] && !sync_c[PIN_SCLK];
  assign sclk_fall = !sync_b[PIN_SCLK] && sync_c[PIN_SCLK];

  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic bit_in, input logic hi_first);
    shift_in = hi_first ? {sr[14:0], bit_in} : {bit_in, sr[15:1]};
  endfunction

  function automatic logic lead_bit(input logic [7:0] b, input logic hi_first);
    lead_bit = hi_first ? b[7] : b[0];
  endfunction

  stp_state_t state;
  stp_state_t next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [15:0] rx_sr;
  logic [15:0] next_rx_sr;
  logic        is_read;
  logic        next_is_read;
  stp_addr_t   addr;
  stp_addr_t   next_addr;
  logic [7:0]  tx_sr;
  logic [7:0]  next_tx_sr;
  logic        out_bit;
  logic        next_out_bit;
  logic        driving;
  logic        next_driving;
  logic        next_rd_req;
  logic        rd_load;
  logic        next_rd_load;
  logic        four_wire;
  logic        next_four_wire;
  logic        hi_first;
  logic        next_hi_first;
  logic        pend;
  logic        next_pend;
  stp_wr_t     pend_word;
  stp_wr_t     next_pend_word;
  logic        overrun;
  logic        next_overrun;
  logic        fifo_in_ready;
  logic [15:0] shifted;
  logic [7:0]  rx_byte;

  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_rx_sr     = rx_sr;
    next_is_read   = is_read;
    next_addr      = addr;
    next_tx_sr     = tx_sr;
    next_out_bit   = out_bit;
    next_driving   = driving;
    next_rd_req    = 1'b0;
    next_rd_load   = rd_req;
    next_four_wire = four_wire;
    next_hi_first  = hi_first;
    next_pend      = pend && !fifo_in_ready;
    next_pend_word = pend_word;
    next_overrun   = 1'b0;
    shifted        = shift_in(rx_sr, din, hi_first);
    rx_byte        = hi_first ? shifted[7:0] : shifted[15:8];

    if (cfg_wr) begin
      next_four_wire = cfg_four_wire;
      next_hi_first  = cfg_high_bit_first;
    end

    // Read data arrives one cycle after the request; misses read as zero.
    if (rd_load) begin
      next_tx_sr = rd_addr_hit ? rd_data : 8'h00;
    end

    if (sel_n) begin
      // Only completed writes already held in pend or the FIFO survive this.
      next_state   = ST_IDLE;
      next_bit_cnt = CNT_RST;
      next_driving = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state   = ST_INSTR;
          next_bit_cnt = CNT_RST;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            next_rx_sr   = shifted;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_INSTR_CNT) begin
              next_is_read = shifted[RW_POS];
              next_addr    = shifted[ADDR_BITS-1:0];
              next_rd_req  = shifted[RW_POS];
              next_bit_cnt = CNT_RST;
              next_state   = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (is_read && sclk_fall) begin
            next_out_bit = lead_bit(tx_sr, hi_first);
            next_tx_sr   = hi_first ? {tx_sr[6:0], 1'b0} : {1'b0, tx_sr[7:1]};
            next_driving = 1'b1;
          end
          if (sclk_rise) begin
            next_rx_sr   = shifted;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_DATA_CNT) begin
              next_driving = 1'b0;
              next_bit_cnt = CNT_RST;
              next_state   = ST_INSTR;
              if (!is_read) begin
                next_pend      = 1'b1;
                next_pend_word = '{addr: addr, data: rx_byte};
                next_overrun   = pend && !fifo_in_ready;
              end
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state     <= ST_IDLE;
      bit_cnt   <= CNT_RST;
      rx_sr     <= 16'h0000;
      is_read   <= 1'b0;
      addr      <= '0;
      tx_sr     <= 8'h00;
      out_bit   <= 1'b0;
      driving   <= 1'b0;
      rd_req    <= 1'b0;
      rd_load   <= 1'b0;
      four_wire <= FOUR_WIRE_RST;
      hi_first  <= HIGH_BIT_FIRST_RST;
      pend      <= 1'b0;
      pend_word <= '0;
      overrun   <= 1'b0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      rx_sr     <= next_rx_sr;
      is_read   <= next_is_read;
      addr      <= next_addr;
      tx_sr     <= next_tx_sr;
      out_bit   <= next_out_bit;
      driving   <= next_driving;
      rd_req    <= next_rd_req;
      rd_load   <= next_rd_load;
      four_wire <= next_four_wire;
      hi_first  <= next_hi_first;
      pend      <= next_pend;
      pend_word <= next_pend_word;
      overrun   <= next_overrun;
    end
  end

  // The serial host cannot be stalled, so a held write waits here for room.
  stp_pair_fifo #(
    .WIDTH ($bits(stp_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_valid  (pend),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  assign data_in_out_out   = out_bit;
  assign data_in_out_oe    = driving && !four_wire;
  assign data_out_line_out = out_bit;
  assign data_out_line_oe  = driving && four_wire;

  assign four_wire_mode     = four_wire;
  assign high_bit_first_sel = hi_first;
  assign rd_addr            = addr;
  assign write_overrun      = overrun;
  assign frame_active       = (state != ST_IDLE);

endmodule

`default_nettype wire

/* File: bench/stp_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module stp_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_select_n,
  input wire logic wr_ready,
  input wire logic wr_valid,
  input wire logic rd_req,
  input wire logic data_in_out_oe,
  input wire logic data_out_line_oe,
  input wire logic four_wire_mode,
  input wire logic high_bit_first_sel,
  input wire logic frame_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  reset_mode_a: assert property ($fell(reset) |-> !four_wire_mode && high_bit_first_sel && !frame_active)
    else $error("bad mode after reset");
  three_wire_a: assert property (!four_wire_mode |-> !data_out_line_oe)
    else $error("output line driven");
  four_wire_a: assert property (four_wire_mode |-> !data_in_out_oe)
    else $error("data pin driven");
  oe_excl_a: assert property (!(data_in_out_oe && data_out_line_oe))
    else $error("both lines driven");
  idle_float_a: assert property (bus_select_n [*6] |-> !data_in_out_oe && !data_out_line_oe && !frame_active)
    else $error("active while idle");
  req_pulse_a: assert property (rd_req |=> !rd_req)
    else $error("long read request");
  req_frame_a: assert property (rd_req |-> frame_active)
    else $error("read outside frame");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid)
    else $error("write word lost");
  cover property (rd_req && four_wire_mode);
  cover property ($rose(data_in_out_oe));
  cover property (wr_valid && !wr_ready);
endmodule
bind stp_target_port stp_sva stp_sva_i (.mclk(mclk), .reset(reset), .bus_select_n(bus_select_n),
  .wr_ready(wr_ready), .wr_valid(wr_valid), .rd_req(rd_req), .data_in_out_oe(data_in_out_oe),
  .data_out_line_oe(data_out_line_oe), .four_wire_mode(four_wire_mode),
  .high_bit_first_sel(high_bit_first_sel), .frame_active(frame_active));
`default_nettype wire

/* File: bench/stp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module stp_host (
  input  wire logic mclk,
  input  wire logic fw,
  input  wire logic dio,
  input  wire logic dol,
  output logic      sck,
  output logic      sel_n,
  output logic      h_d,
  output logic      h_oe
);
  initial {sck, sel_n, h_d, h_oe} = 4'h4;
  task automatic frm(input logic on);
    @(negedge mclk);
    sck = 1'b0;
    repeat (3) @(negedge mclk);
    sel_n = !on;
    h_oe = on;
    repeat (6) @(negedge mclk);
  endtask
  // Sends the first n of 24 bits; the clock is low 5 and high 3 cycles.
  task automatic pair(input logic rw, input logic hbf, input logic [14:0] a, input logic [7:0] d,
                      input int n, output logic [7:0] q);
    logic [23:0] v;
    v = {rw, a, d};
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      sck = 1'b0;
      h_oe = !(rw && i > 15);
      h_d = hbf ? v[23-i] : (i < 15 ? a[i] : (i == 15 ? rw : d[i-16]));
      repeat (5) @(negedge mclk);
      sck = 1'b1;
      if (i > 15) q[hbf ? 23-i : i-16] = fw ? dol : dio;
      repeat (2) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/stp_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module stp_target_port_tb_top;
  import stp_pkg::*;
  logic        reset = 1'b1, cfg_wr = 1'b0, cfg_fw = 1'b0, cfg_hbf = 1'b1, wr_ready = 1'b0, hit = 1'b0;
  logic        mclk, flt = 1'b0, dio_out, dio_oe, dol_out, dol_oe, fwm, hbfm, rd_req, wr_valid, fa, ovr;
  logic        sck, sel_n, h_d, h_oe, stall = 1'b0;
  logic [7:0]  rd_data = 8'h00, q, d, mem [256];
  logic [31:0] rs = 32'h49;
  stp_addr_t   rd_addr, a;
  stp_wr_t     wr_word;
  int          n_fail = 0, checks_done = 0, nwr = 0, exp_wr = 0, n_ovr = 0;
  wire logic   dio = dio_oe ? dio_out : (h_oe ? h_d : flt);
  wire logic   dol = dol_oe ? dol_out : flt;
  stp_target_port stp_target_port_i (.mclk(mclk), .reset(reset), .serial_clock_in(sck), .bus_select_n(sel_n),
    .data_in_out_in(dio), .data_in_out_out(dio_out), .data_in_out_oe(dio_oe), .data_out_line_out(dol_out),
    .data_out_line_oe(dol_oe), .cfg_wr(cfg_wr), .cfg_four_wire(cfg_fw), .cfg_high_bit_first(cfg_hbf),
    .four_wire_mode(fwm), .high_bit_first_sel(hbfm), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_addr_hit(hit), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .write_overrun(ovr),
    .frame_active(fa));
  stp_host stp_host_i (.mclk(mclk), .fw(cfg_fw), .dio(dio), .dol(dol), .sck(sck), .sel_n(sel_n), .h_d(h_d),
    .h_oe(h_oe));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] exp_rd(input stp_addr_t ad, input logic [7:0] wd);
    return ad < 15'h0100 ? wd : 8'h00;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic drain();
    for (int i = 0; i < 80 && wr_valid !== 1'b0; i++) @(negedge mclk);
    if (wr_valid !== 1'b0) begin
      n_fail++;
      conclude();
    end else begin
      `CK("write count", exp_wr, nwr)
    end
  endtask
  task automatic cfg(input logic f, input logic h);
    @(negedge mclk);
    cfg_fw = f;
    cfg_hbf = h;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
  endtask
  task automatic one(input logic rw, input stp_addr_t ad, input logic [7:0] wd, input int n);
    stp_host_i.frm(1'b1);
    `CK("frame active", 1'b1, fa)
    stp_host_i.pair(rw, cfg_hbf, ad, wd, n, q);
    stp_host_i.frm(1'b0);
    `CK("frame idle", 1'b0, fa)
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Undefined addresses return junk here, so the port must zero them itself.
  always @(negedge mclk) begin
    flt <= ~flt;
    rs <= xs(rs);
    wr_ready <= !stall && rs[1:0] != 2'h0;
    hit <= rd_addr < 15'h0100;
    rd_data <= rd_addr < 15'h0100 ? mem[rd_addr[7:0]] : 8'hA5;
  end
  always @(posedge mclk) if (ovr === 1'b1) n_ovr <= n_ovr + 1;
  always @(posedge mclk) if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
    nwr <= nwr + 1;
    if (wr_word.addr < 15'h0100) mem[wr_word.addr[7:0]] <= wr_word.data;
  end
  initial begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    repeat (3) @(negedge mclk);
    `CK("reset mode", 2'h1, {fwm, hbfm})
    for (int k = 0; k < 8; k++) begin
      cfg(k[0], k[1]);
      a = k[2] ? {1'b1, rs[13:0]} : {7'h00, rs[7:0]};
      d = rs[15:8];
      exp_wr++;
      one(1'b0, a, d, 24);
      drain();
      one(1'b1, a, 8'h00, 24);
      `CK("read byte", exp_rd(a, d), q)
      $display("pair test %0d done", k);
    end
    cfg(1'b0, 1'b1);
    // With the sink stalled, two words fill the buffer, one is held and the fourth replaces it.
    stall = 1'b1;
    stp_host_i.frm(1'b1);
    for (int j = 0; j < 5; j++) stp_host_i.pair(1'b0, 1'b1, 15'(j + 16), 8'(j + 60), j < 4 ? 24 : 20, q);
    stp_host_i.frm(1'b0);
    stall = 1'b0;
    exp_wr += 3;
    drain();
    `CK("overrun count", 1, n_ovr)
    one(1'b0, 15'h0013, 8'h11, 10);
    drain();
    stp_host_i.frm(1'b1);
    for (int j = 0; j < 4; j++) begin
      if (j != 2) begin
        stp_host_i.pair(1'b1, 1'b1, 15'(j + 16), 8'h00, 24, q);
        `CK("buffered read", 8'(j + 60), q)
      end
    end
    stp_host_i.frm(1'b0);
    $display("buffered and abort test done");
    conclude();
  end
endmodule
`default_nettype wire
